// File: design/spfs_pin_mux.sv
`timescale 1ns/1ps
`include "spfs_consts.svh"
// Summary of operation
// - clock-out and serial port 2 clock pins leave reset in clock function, enables clear.
// - gpio enable bit set hands that pin to the gpio function.
// - enabled gpio pin: direction 0 is input, direction 1 drives output.
// - gpio pins 9 to 15 are gpio only while pci strap is 0.
// - atm strap low: shared pins carry serial port 1, atm port disabled.
// - atm strap high: shared serial port 1 pins become atm address pins.
// - pci strap low: shared host/pci pins carry host port functions.
// - pci strap high: all shared host pins, data included, carry pci signals.
// - straps latched once after reset ends and the synchroniser settles, then fixed; software pins switch whenever clkEn is high.
// - standalone atm and pci pads held undriven while their peripheral is deselected.
// - eeprom takes serial port 2 pins only with pci 1 and serial port 2 strap 0.
module spfs_pin_mux (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          clkEn,
	input  wire logic                          atmPortSelectStrap,
	input  wire logic                          pciSelectStrap,
	input  wire logic                          serialPort2SelectStrap,
	output logic                               strapsLocked,
	output logic                               atmPortEnable,
	output logic                               pciPortEnable,
	output logic                               hostPortEnable,
	output logic                               eepromEnable,
	input  wire logic [`SPFS_GPIO_W-1:0]       gpioPinEnableBit,
	input  wire logic [`SPFS_GPIO_W-1:0]       gpioPinDirectionBit,
	input  wire logic [`SPFS_GPIO_W-1:0]       gpioOut,
	output logic      [`SPFS_GPIO_W-1:0]       gpioIn,
	input  wire logic                          quarterRateClockOut,
	input  wire logic                          sixthRateClockOut,
	output logic                               serialPort2ExtClock,
	input  wire logic [`SPFS_PCI_SIDE_W-1:0]   pciSideOut,
	input  wire logic [`SPFS_PCI_SIDE_W-1:0]   pciSideOe,
	output logic      [`SPFS_PCI_SIDE_W-1:0]   pciSideIn,
	input  wire logic [`SPFS_GPIO_W-1:0]       gpPadIn,
	output logic      [`SPFS_GPIO_W-1:0]       gpPadOut,
	output logic      [`SPFS_GPIO_W-1:0]       gpPadOe,
	input  wire logic [`SPFS_SP1_W-1:0]        sp1Out,
	input  wire logic [`SPFS_SP1_W-1:0]        sp1Oe,
	output logic      [`SPFS_SP1_W-1:0]        sp1In,
	output logic      [`SPFS_SP1_W-1:0]        atmAddrIn,
	input  wire logic [`SPFS_SP1_W-1:0]        sp1PadIn,
	output logic      [`SPFS_SP1_W-1:0]        sp1PadOut,
	output logic      [`SPFS_SP1_W-1:0]        sp1PadOe,
	input  wire logic [`SPFS_ATM_ALONE_W-1:0]  atmAloneOut,
	input  wire logic [`SPFS_ATM_ALONE_W-1:0]  atmAloneOe,
	output logic      [`SPFS_ATM_ALONE_W-1:0]  atmAloneIn,
	input  wire logic [`SPFS_ATM_ALONE_W-1:0]  atmAlonePadIn,
	output logic      [`SPFS_ATM_ALONE_W-1:0]  atmAlonePadOut,
	output logic      [`SPFS_ATM_ALONE_W-1:0]  atmAlonePadOe,
	input  wire logic [`SPFS_HOST_W-1:0]       hostOut,
	input  wire logic [`SPFS_HOST_W-1:0]       hostOe,
	output logic      [`SPFS_HOST_W-1:0]       hostIn,
	input  wire logic [`SPFS_HOST_W-1:0]       pciOut,
	input  wire logic [`SPFS_HOST_W-1:0]       pciOe,
	output logic      [`SPFS_HOST_W-1:0]       pciIn,
	input  wire logic [`SPFS_HOST_W-1:0]       hostPadIn,
	output logic      [`SPFS_HOST_W-1:0]       hostPadOut,
	output logic      [`SPFS_HOST_W-1:0]       hostPadOe,
	input  wire logic [`SPFS_PCI_ALONE_W-1:0]  pciAloneOut,
	input  wire logic [`SPFS_PCI_ALONE_W-1:0]  pciAloneOe,
	output logic      [`SPFS_PCI_ALONE_W-1:0]  pciAloneIn,
	input  wire logic [`SPFS_PCI_ALONE_W-1:0]  pciAlonePadIn,
	output logic      [`SPFS_PCI_ALONE_W-1:0]  pciAlonePadOut,
	output logic      [`SPFS_PCI_ALONE_W-1:0]  pciAlonePadOe,
	input  wire logic [`SPFS_SP2_W-1:0]        sp2Out,
	input  wire logic [`SPFS_SP2_W-1:0]        sp2Oe,
	output logic      [`SPFS_SP2_W-1:0]        sp2In,
	input  wire logic [`SPFS_SP2_W-1:0]        eepromOut,
	input  wire logic [`SPFS_SP2_W-1:0]        eepromOe,
	output logic      [`SPFS_SP2_W-1:0]        eepromIn,
	input  wire logic [`SPFS_SP2_W-1:0]        sp2PadIn,
	output logic      [`SPFS_SP2_W-1:0]        sp2PadOut,
	output logic      [`SPFS_SP2_W-1:0]        sp2PadOe
);
	spfs_sync_if #(.W(`SPFS_SYNC_W)) syncBus ();

	spfs_pkg::spfs_strap_t                strapS;
	logic [`SPFS_PCI_ALONE_W-1:0]         pciAloneS;
	logic [`SPFS_ATM_ALONE_W-1:0]         atmAloneS;
	logic [`SPFS_SP2_W-1:0]               sp2S;
	logic [`SPFS_HOST_W-1:0]              hostS;
	logic [`SPFS_SP1_W-1:0]               sp1S;
	logic [`SPFS_GPIO_W-1:0]              gpS;
	logic [`SPFS_SYNC_W-1:0]              agreeAll;
	logic                                 strapAgree;

	spfs_pkg::spfs_phase_t                phase;
	spfs_pkg::spfs_phase_t                next_phase;
	spfs_pkg::spfs_strap_t                strap;
	spfs_pkg::spfs_strap_t                next_strap;
	logic [1:0]                           settleCount;
	logic [1:0]                           next_settleCount;
	logic                                 strapArmed;
	logic                                 next_strapArmed;

	logic [`SPFS_GPIO_W-1:0]              gpOwn;
	logic [`SPFS_GPIO_W-1:0]              dflOut;
	logic [`SPFS_GPIO_W-1:0]              dflOe;
	logic                                 eepromSel;

	logic [`SPFS_GPIO_W-1:0]              next_gpPadOut;
	logic [`SPFS_GPIO_W-1:0]              next_gpPadOe;
	logic [`SPFS_GPIO_W-1:0]              next_gpioIn;
	logic                                 next_serialPort2ExtClock;
	logic [`SPFS_PCI_SIDE_W-1:0]          next_pciSideIn;
	logic [`SPFS_SP1_W-1:0]               next_sp1PadOut;
	logic [`SPFS_SP1_W-1:0]               next_sp1PadOe;
	logic [`SPFS_SP1_W-1:0]               next_sp1In;
	logic [`SPFS_SP1_W-1:0]               next_atmAddrIn;
	logic [`SPFS_ATM_ALONE_W-1:0]         next_atmAlonePadOut;
	logic [`SPFS_ATM_ALONE_W-1:0]         next_atmAlonePadOe;
	logic [`SPFS_ATM_ALONE_W-1:0]         next_atmAloneIn;
	logic [`SPFS_HOST_W-1:0]              next_hostPadOut;
	logic [`SPFS_HOST_W-1:0]              next_hostPadOe;
	logic [`SPFS_HOST_W-1:0]              next_hostIn;
	logic [`SPFS_HOST_W-1:0]              next_pciIn;
	logic [`SPFS_PCI_ALONE_W-1:0]         next_pciAlonePadOut;
	logic [`SPFS_PCI_ALONE_W-1:0]         next_pciAlonePadOe;
	logic [`SPFS_PCI_ALONE_W-1:0]         next_pciAloneIn;
	logic [`SPFS_SP2_W-1:0]               next_sp2PadOut;
	logic [`SPFS_SP2_W-1:0]               next_sp2PadOe;
	logic [`SPFS_SP2_W-1:0]               next_sp2In;
	logic [`SPFS_SP2_W-1:0]               next_eepromIn;

	// every pad input, straps included, goes through the three-stage synchroniser
	assign syncBus.raw = {serialPort2SelectStrap, pciSelectStrap, atmPortSelectStrap,
		pciAlonePadIn, atmAlonePadIn, sp2PadIn, hostPadIn, sp1PadIn, gpPadIn};
	assign {strapS, pciAloneS, atmAloneS, sp2S, hostS, sp1S, gpS} = syncBus.clean;
	assign agreeAll = syncBus.agree;
	assign strapAgree = &agreeAll[`SPFS_SYNC_W-1 -: `SPFS_STRAP_W];

	spfs_pin_sync #(.W(`SPFS_SYNC_W)) u_sync (
		.clk   (clk),
		.rst   (rst),
		.clkEn (clkEn),
		.pins  (syncBus)
	);

	// strap capture: the sync chain is refilled after reset, so wait for it to settle
	always_comb begin
		next_phase       = phase;
		next_strap       = strap;
		next_settleCount = settleCount;
		next_strapArmed  = strapArmed;
		case (phase)
			spfs_pkg::SPFS_CAPTURE: begin
				// clean lags the agreeing stages by one edge, so latch one edge after they agree
				if (settleCount != `SPFS_SETTLE) begin
					next_settleCount = settleCount + 2'h1;
				end else if (strapAgree && !strapArmed) begin
					next_strapArmed = 1'b1;
				end else if (strapAgree) begin
					next_strap = strapS;
					next_phase = spfs_pkg::SPFS_LOCKED;
				end else begin
					next_strapArmed = 1'b0;
				end
			end
			spfs_pkg::SPFS_LOCKED: begin
				next_phase = spfs_pkg::SPFS_LOCKED;
			end
			default: begin
				next_phase = spfs_pkg::SPFS_CAPTURE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase       <= spfs_pkg::SPFS_CAPTURE;
			strap       <= `SPFS_STRAP_RESET;
			settleCount <= 2'h0;
			strapArmed  <= 1'b0;
		end else if (clkEn) begin
			phase       <= next_phase;
			strap       <= next_strap;
			settleCount <= next_settleCount;
			strapArmed  <= next_strapArmed;
		end
	end

	// per-pin default function of the gpio pads
	genvar g;
	generate
		for (g = 0; g < `SPFS_GPIO_W; g++) begin : gpBit
			localparam bit PCI_PIN = (g >= `SPFS_GP_PCI_LO) && (g <= `SPFS_GP_PCI_HI);
			assign gpOwn[g] = gpioPinEnableBit[g] && !(PCI_PIN && strap.pci);
			if (g == `SPFS_GP_QCLK) begin : qclk
				assign dflOut[g] = quarterRateClockOut;
				assign dflOe[g]  = 1'b1;
			end else if (g == `SPFS_GP_SCLK) begin : sclk
				assign dflOut[g] = sixthRateClockOut;
				assign dflOe[g]  = 1'b1;
			end else if (PCI_PIN) begin : pciPin
				assign dflOut[g] = pciSideOut[g-`SPFS_GP_PCI_LO];
				assign dflOe[g]  = strap.pci && pciSideOe[g-`SPFS_GP_PCI_LO];
			end else begin : plain
				assign dflOut[g] = 1'b0;
				assign dflOe[g]  = 1'b0;
			end
		end
	endgenerate

	assign eepromSel = strap.pci && !strap.sp2;

	always_comb begin
		// gpio pads: direction only counts while the pin is owned by gpio
		next_gpPadOut = (gpOwn & gpioOut) | (~gpOwn & dflOut);
		next_gpPadOe  = (gpOwn & gpioPinDirectionBit) | (~gpOwn & dflOe);
		next_gpioIn   = gpOwn & gpS;
		next_serialPort2ExtClock = !gpOwn[`SPFS_GP_SP2CLK] && gpS[`SPFS_GP_SP2CLK];
		next_pciSideIn = strap.pci ? gpS[`SPFS_GP_PCI_HI:`SPFS_GP_PCI_LO] : '0;
		// serial port 1 or atm address pins; atm address lines are inputs
		next_sp1PadOut = strap.atm ? '0 : sp1Out;
		next_sp1PadOe  = strap.atm ? '0 : sp1Oe;
		next_sp1In     = strap.atm ? '0 : sp1S;
		next_atmAddrIn = strap.atm ? sp1S : '0;
		// standalone pads are tied off rather than left to a deselected peripheral
		next_atmAlonePadOut = strap.atm ? atmAloneOut : '0;
		next_atmAlonePadOe  = strap.atm ? atmAloneOe : '0;
		next_atmAloneIn     = strap.atm ? atmAloneS : '0;
		next_pciAlonePadOut = strap.pci ? pciAloneOut : '0;
		next_pciAlonePadOe  = strap.pci ? pciAloneOe : '0;
		next_pciAloneIn     = strap.pci ? pciAloneS : '0;
		// host port or pci on the shared data and control pins
		next_hostPadOut = strap.pci ? pciOut : hostOut;
		next_hostPadOe  = strap.pci ? pciOe : hostOe;
		next_hostIn     = strap.pci ? '0 : hostS;
		next_pciIn      = strap.pci ? hostS : '0;
		// serial port 2 pins, taken by the eeprom only with pci strap 1 and serial port 2 strap 0
		next_sp2PadOut = eepromSel ? eepromOut : sp2Out;
		next_sp2PadOe  = eepromSel ? eepromOe : sp2Oe;
		next_sp2In     = eepromSel ? '0 : sp2S;
		next_eepromIn  = eepromSel ? sp2S : '0;
	end

	// reset value drives no pad at all, clock outs included; default owners take over once reset ends
	always_ff @(posedge clk) begin
		if (rst) begin
			gpPadOut            <= '0;
			gpPadOe             <= '0;
			gpioIn              <= '0;
			serialPort2ExtClock <= 1'b0;
			pciSideIn           <= '0;
			sp1PadOut           <= '0;
			sp1PadOe            <= '0;
			sp1In               <= '0;
			atmAddrIn           <= '0;
			atmAlonePadOut      <= '0;
			atmAlonePadOe       <= '0;
			atmAloneIn          <= '0;
			pciAlonePadOut      <= '0;
			pciAlonePadOe       <= '0;
			pciAloneIn          <= '0;
			hostPadOut          <= '0;
			hostPadOe           <= '0;
			hostIn              <= '0;
			pciIn               <= '0;
			sp2PadOut           <= '0;
			sp2PadOe            <= '0;
			sp2In               <= '0;
			eepromIn            <= '0;
		end else if (clkEn) begin
			gpPadOut            <= next_gpPadOut;
			gpPadOe             <= next_gpPadOe;
			gpioIn              <= next_gpioIn;
			serialPort2ExtClock <= next_serialPort2ExtClock;
			pciSideIn           <= next_pciSideIn;
			sp1PadOut           <= next_sp1PadOut;
			sp1PadOe            <= next_sp1PadOe;
			sp1In               <= next_sp1In;
			atmAddrIn           <= next_atmAddrIn;
			atmAlonePadOut      <= next_atmAlonePadOut;
			atmAlonePadOe       <= next_atmAlonePadOe;
			atmAloneIn          <= next_atmAloneIn;
			pciAlonePadOut      <= next_pciAlonePadOut;
			pciAlonePadOe       <= next_pciAlonePadOe;
			pciAloneIn          <= next_pciAloneIn;
			hostPadOut          <= next_hostPadOut;
			hostPadOe           <= next_hostPadOe;
			hostIn              <= next_hostIn;
			pciIn               <= next_pciIn;
			sp2PadOut           <= next_sp2PadOut;
			sp2PadOe            <= next_sp2PadOe;
			sp2In               <= next_sp2In;
			eepromIn            <= next_eepromIn;
		end
	end

	assign strapsLocked   = (phase == spfs_pkg::SPFS_LOCKED);
	assign atmPortEnable  = strap.atm;
	assign pciPortEnable  = strap.pci;
	assign hostPortEnable = !strap.pci;
	assign eepromEnable   = eepromSel;
endmodule : spfs_pin_mux

// File: design/spfs_consts.svh
`ifndef SPFS_CONSTS_SVH
`define SPFS_CONSTS_SVH

// pad group widths
`define SPFS_GPIO_W      16
`define SPFS_SP1_W       7
`define SPFS_HOST_W      42
`define SPFS_SP2_W       3
`define SPFS_ATM_ALONE_W 16
`define SPFS_PCI_ALONE_W 8
`define SPFS_STRAP_W     3
`define SPFS_SYNC_W      95

// gpio pin positions of shared functions
`define SPFS_GP_QCLK     1
`define SPFS_GP_SCLK     2
`define SPFS_GP_SP2CLK   8
`define SPFS_GP_PCI_LO   9
`define SPFS_GP_PCI_HI   15
`define SPFS_PCI_SIDE_W  7

// reset values and strap settling count
`define SPFS_STRAP_RESET 3'h0
`define SPFS_SETTLE      2'h3

`endif

// File: design/spfs_pkg.sv
package spfs_pkg;

	typedef enum logic {
		SPFS_CAPTURE = 1'b0,
		SPFS_LOCKED  = 1'b1
	} spfs_phase_t;

	typedef struct packed {
		logic sp2;
		logic pci;
		logic atm;
	} spfs_strap_t;

endpackage : spfs_pkg

// File: design/spfs_sync_if.sv
`timescale 1ns/1ps
interface spfs_sync_if #(
	parameter int W = 1
);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	logic [W-1:0] agree;

	modport syncer (
		input  raw,
		output clean,
		output agree
	);
	modport user (
		output raw,
		input  clean,
		input  agree
	);
endinterface : spfs_sync_if

// File: design/spfs_pin_sync.sv
`timescale 1ns/1ps
module spfs_pin_sync #(
	parameter int W = 1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clkEn,
	spfs_sync_if.syncer pins
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] clean;
	logic [W-1:0] next_clean;

	// a change is taken only once the second and third stage agree
	always_comb begin
		next_clean = (clean & (stage2 ^ stage3)) | (stage3 & ~(stage2 ^ stage3));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			clean  <= '0;
		end else if (clkEn) begin
			stage1 <= pins.raw;
			stage2 <= stage1;
			stage3 <= stage2;
			clean  <= next_clean;
		end
	end

	assign pins.clean = clean;
	assign pins.agree = ~(stage2 ^ stage3);
endmodule : spfs_pin_sync

// File: dv/spfs_pin_mux_monitor.sv
`timescale 1ns/1ps
`include "spfs_consts.svh"
module spfs_pin_mux_monitor (
	input wire logic                           clk,
	input wire logic                           rst,
	input wire logic                           clkEn,
	input wire logic                           strapsLocked,
	input wire logic                           atmPortEnable,
	input wire logic                           pciPortEnable,
	input wire logic                           hostPortEnable,
	input wire logic                           eepromEnable,
	input wire logic [`SPFS_GPIO_W-1:0]        gpioPinEnableBit,
	input wire logic [`SPFS_GPIO_W-1:0]        gpioPinDirectionBit,
	input wire logic [`SPFS_GPIO_W-1:0]        gpioOut,
	input wire logic                           quarterRateClockOut,
	input wire logic [`SPFS_PCI_SIDE_W-1:0]    pciSideOe,
	input wire logic [`SPFS_GPIO_W-1:0]        gpPadOut,
	input wire logic [`SPFS_GPIO_W-1:0]        gpPadOe,
	input wire logic [`SPFS_SP1_W-1:0]         sp1Oe,
	input wire logic [`SPFS_SP1_W-1:0]         sp1PadOe,
	input wire logic [`SPFS_ATM_ALONE_W-1:0]   atmAlonePadOe,
	input wire logic [`SPFS_PCI_ALONE_W-1:0]   pciAlonePadOe,
	input wire logic [`SPFS_HOST_W-1:0]        hostOe,
	input wire logic [`SPFS_HOST_W-1:0]        pciOe,
	input wire logic [`SPFS_HOST_W-1:0]        hostPadOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// pin 3 has no default function, so it shows the gpio path alone
	property p_gp_out; clkEn && gpioPinEnableBit[3] && gpioPinDirectionBit[3] |=> gpPadOe[3] && gpPadOut[3] == $past(gpioOut[3]); endproperty
	a_gp_out: assert property (p_gp_out) else $error("gpio output pin not driven");
	property p_gp_in; clkEn && gpioPinEnableBit[3] && !gpioPinDirectionBit[3] |=> !gpPadOe[3]; endproperty
	a_gp_in: assert property (p_gp_in) else $error("gpio input pin driven");
	property p_clk_dflt; clkEn && !gpioPinEnableBit[1] |=> gpPadOe[1] && gpPadOut[1] == $past(quarterRateClockOut); endproperty
	a_clk_dflt: assert property (p_clk_dflt) else $error("clock pin lost default function");
	property p_pci_side; clkEn && pciPortEnable |=> gpPadOe[15:9] == $past(pciSideOe); endproperty
	a_pci_side: assert property (p_pci_side) else $error("pci side pins not owned by pci");
	property p_host; clkEn && hostPortEnable |=> hostPadOe == $past(hostOe); endproperty
	a_host: assert property (p_host) else $error("host pads not owned by host port");
	property p_pci_host; clkEn && pciPortEnable |=> hostPadOe == $past(pciOe); endproperty
	a_pci_host: assert property (p_pci_host) else $error("shared pads not owned by pci");
	property p_alone; clkEn |=> (atmAlonePadOe == '0 || $past(atmPortEnable)) && (pciAlonePadOe == '0 || $past(pciPortEnable)); endproperty
	a_alone: assert property (p_alone) else $error("standalone pads driven while deselected");
	property p_sp1; clkEn |=> sp1PadOe == ($past(atmPortEnable) ? 7'h00 : $past(sp1Oe)); endproperty
	a_sp1: assert property (p_sp1) else $error("serial port 1 pads wrongly owned");
	property p_lock; strapsLocked |=> strapsLocked && $stable({atmPortEnable, pciPortEnable, eepromEnable}); endproperty
	a_lock: assert property (p_lock) else $error("strap selection changed after lock");
	property p_owner; strapsLocked |-> hostPortEnable != pciPortEnable && (!eepromEnable || pciPortEnable); endproperty
	a_owner: assert property (p_owner) else $error("pin group owner conflict");
endmodule : spfs_pin_mux_monitor
bind spfs_pin_mux spfs_pin_mux_monitor spfs_pin_mux_monitor_i (.clk, .rst, .clkEn, .strapsLocked, .atmPortEnable,
	.pciPortEnable, .hostPortEnable, .eepromEnable, .gpioPinEnableBit, .gpioPinDirectionBit, .gpioOut,
	.quarterRateClockOut, .pciSideOe, .gpPadOut, .gpPadOe, .sp1Oe, .sp1PadOe, .atmAlonePadOe, .pciAlonePadOe,
	.hostOe, .pciOe, .hostPadOe);

// File: dv/spfs_board_model.sv
`timescale 1ns/1ps
module spfs_board_model (
	input  wire logic [15:0] padOut,
	input  wire logic [15:0] padOe,
	input  wire logic [15:0] boardLevel,
	input  wire logic [15:0] boardDrive,
	output logic      [15:0] padIn
);
	// board drives only lines the device leaves free; an undriven line falls to its pull-down
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			padIn[k] = padOe[k] ? padOut[k] : (boardDrive[k] & boardLevel[k]);
		end
	end
endmodule : spfs_board_model

// File: dv/spfs_pin_mux_tb.sv
`timescale 1ns/1ps
module spfs_pin_mux_tb;
	logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, pciOn = 1'b0;
	logic atmPortSelectStrap = 1'b0, pciSelectStrap = 1'b0, serialPort2SelectStrap = 1'b0;
	logic strapsLocked, atmPortEnable, pciPortEnable, hostPortEnable, eepromEnable, serialPort2ExtClock;
	logic quarterRateClockOut = 1'b1, sixthRateClockOut = 1'b1;
	logic [15:0] gpioPinEnableBit = '0, gpioPinDirectionBit = '0, gpioOut = '0, gpioIn;
	logic [15:0] gpPadIn, gpPadOut, gpPadOe, boardLevel = '0, boardDrive = '0;
	logic [6:0] pciSideOut = 7'h55, pciSideOe = 7'h3C, pciSideIn, sp1Out = 7'h2A, sp1Oe = 7'h63;
	logic [6:0] sp1In, atmAddrIn, sp1PadIn = 7'h19, sp1PadOut, sp1PadOe;
	logic [15:0] atmAloneOut = 16'hA5C3, atmAloneOe = 16'hF0F0, atmAloneIn, atmAlonePadIn = 16'h3C5A;
	logic [15:0] atmAlonePadOut, atmAlonePadOe;
	logic [41:0] hostOut = 42'h1F0F0F0F0F0, hostOe = 42'h2AA55AA55AA, hostIn, hostPadOut, hostPadOe;
	logic [41:0] pciOut = 42'h3C3C3C3C3C3, pciOe = 42'h15A5A5A5A5A, pciIn, hostPadIn = 42'h0123456789A;
	logic [7:0] pciAloneOut = 8'hC6, pciAloneOe = 8'h9B, pciAloneIn, pciAlonePadIn = 8'h71, pciAlonePadOut;
	logic [7:0] pciAlonePadOe;
	logic [2:0] sp2Out = 3'h5, sp2Oe = 3'h6, sp2In, eepromOut = 3'h2, eepromOe = 3'h3, eepromIn;
	logic [2:0] sp2PadIn = 3'h1, sp2PadOut, sp2PadOe;
	int miscompares = 0, checks_done = 0, cycles = 0;

	spfs_pin_mux spfs_pin_mux_i (.clk, .rst, .clkEn, .atmPortSelectStrap, .pciSelectStrap, .serialPort2SelectStrap,
		.strapsLocked, .atmPortEnable, .pciPortEnable, .hostPortEnable, .eepromEnable, .gpioPinEnableBit,
		.gpioPinDirectionBit, .gpioOut, .gpioIn, .quarterRateClockOut, .sixthRateClockOut, .serialPort2ExtClock,
		.pciSideOut, .pciSideOe, .pciSideIn, .gpPadIn, .gpPadOut, .gpPadOe, .sp1Out, .sp1Oe, .sp1In, .atmAddrIn,
		.sp1PadIn, .sp1PadOut, .sp1PadOe, .atmAloneOut, .atmAloneOe, .atmAloneIn, .atmAlonePadIn, .atmAlonePadOut,
		.atmAlonePadOe, .hostOut, .hostOe, .hostIn, .pciOut, .pciOe, .pciIn, .hostPadIn, .hostPadOut, .hostPadOe,
		.pciAloneOut, .pciAloneOe, .pciAloneIn, .pciAlonePadIn, .pciAlonePadOut, .pciAlonePadOe, .sp2Out, .sp2Oe,
		.sp2In, .eepromOut, .eepromOe, .eepromIn, .sp2PadIn, .sp2PadOut, .sp2PadOe);
	spfs_board_model spfs_board_model_i (.padOut(gpPadOut), .padOe(gpPadOe), .boardLevel, .boardDrive,
		.padIn(gpPadIn));

	always #12.5 clk = ~clk;

	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// generous ceiling: the whole sequence needs under two hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step

	task automatic boot(input spfs_pkg::spfs_strap_t s);
		rst = 1'b1;
		{serialPort2SelectStrap, pciSelectStrap, atmPortSelectStrap} = s;
		pciOn = s.pci;
		step(8);
		chk(gpPadOe, 16'h0000);
		rst = 1'b0;
		for (int i = 0; i < 20 && strapsLocked !== 1'b1; i++) step(1);
		step(2);
		chk({atmPortEnable, pciPortEnable, hostPortEnable, eepromEnable}, {s.atm, s.pci, !s.pci, s.pci & !s.sp2});
	endtask : boot

	task automatic test_straps;
		spfs_pkg::spfs_strap_t tbl [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
		foreach (tbl[i]) begin
			boot(tbl[i]);
			chk(hostPadOe, tbl[i].pci ? pciOe : hostOe);
			chk(hostPadOut, tbl[i].pci ? pciOut : hostOut);
			chk(atmAlonePadOe, tbl[i].atm ? atmAloneOe : 16'h0000);
			chk(pciAlonePadOe, tbl[i].pci ? pciAloneOe : 8'h00);
			chk(sp1PadOe, tbl[i].atm ? 7'h00 : sp1Oe);
			chk(sp2PadOut, (tbl[i].pci && !tbl[i].sp2) ? eepromOut : sp2Out);
			chk(hostIn, tbl[i].pci ? 42'h0 : hostPadIn);
			chk(pciIn, tbl[i].pci ? hostPadIn : 42'h0);
			chk(atmAddrIn, tbl[i].atm ? sp1PadIn : 7'h00);
			chk(sp1In, tbl[i].atm ? 7'h00 : sp1PadIn);
			chk(sp1PadOut, tbl[i].atm ? 7'h00 : sp1Out);
			chk(atmAlonePadOut, tbl[i].atm ? atmAloneOut : 16'h0000);
			chk(atmAloneIn, tbl[i].atm ? atmAlonePadIn : 16'h0000);
			chk(pciAlonePadOut, tbl[i].pci ? pciAloneOut : 8'h00);
			chk(pciAloneIn, tbl[i].pci ? pciAlonePadIn : 8'h00);
			chk(sp2PadOe, (tbl[i].pci && !tbl[i].sp2) ? eepromOe : sp2Oe);
			chk(sp2In, (tbl[i].pci && !tbl[i].sp2) ? 3'h0 : sp2PadIn);
			chk(eepromIn, (tbl[i].pci && !tbl[i].sp2) ? sp2PadIn : 3'h0);
			{serialPort2SelectStrap, pciSelectStrap, atmPortSelectStrap} = ~tbl[i];
			step(8);
			chk({atmPortEnable, pciPortEnable, eepromEnable}, {tbl[i].atm, tbl[i].pci, tbl[i].pci & !tbl[i].sp2});
		end
		$display("test straps done");
	endtask : test_straps

	function automatic logic [1:0] dflt(input int k);
		if (pciOn && k >= 9) return {pciSideOe[k-9], pciSideOut[k-9]};
		if (k == 1) return {1'b1, quarterRateClockOut};
		if (k == 2) return {1'b1, sixthRateClockOut};
		return 2'b00;
	endfunction : dflt

	task automatic test_gpio;
		int pins [5] = '{1, 2, 3, 8, 12};
		foreach (pins[i]) begin
			gpioPinEnableBit[pins[i]] = 1'b1;
			gpioPinDirectionBit[pins[i]] = 1'b1;
			gpioOut[pins[i]] = 1'b1;
			step(1);
			chk({gpPadOe[pins[i]], gpPadOut[pins[i]]}, (pciOn && pins[i] >= 9) ? dflt(pins[i]) : 2'b11);
			gpioPinDirectionBit[pins[i]] = 1'b0;
			step(1);
			chk(gpPadOe[pins[i]], (pciOn && pins[i] >= 9) ? pciSideOe[pins[i]-9] : 1'b0);
			gpioPinEnableBit[pins[i]] = 1'b0;
			gpioPinDirectionBit[pins[i]] = 1'b1;
			step(1);
			chk({gpPadOe[pins[i]], gpPadOut[pins[i]]}, dflt(pins[i]));
		end
		chk(pciSideIn, pciOn ? (pciSideOut & pciSideOe) : 7'h00);
		$display("test gpio done");
	endtask : test_gpio

	task automatic test_pad_in;
		boardDrive = 16'h0108;
		boardLevel = 16'h0108;
		gpioPinEnableBit[3] = 1'b1;
		gpioPinDirectionBit = 16'h0000;
		step(6);
		chk(gpioIn[3], 1'b1);
		chk(serialPort2ExtClock, 1'b1);
		gpioPinEnableBit[8] = 1'b1;
		boardDrive = 16'h0100;
		// a falling pad must not show before the second and third stage agree
		step(4);
		chk(gpioIn[3], 1'b1);
		step(2);
		chk(gpioIn[8], 1'b1);
		chk(serialPort2ExtClock, 1'b0);
		chk(gpioIn[3], 1'b0);
		gpioPinEnableBit = 16'h0000;
		boardDrive = 16'h0000;
		$display("test pad input done");
	endtask : test_pad_in

	task automatic test_freeze;
		step(1);
		clkEn = 1'b0;
		gpioPinEnableBit[3] = 1'b1;
		gpioPinDirectionBit[3] = 1'b1;
		step(3);
		chk(gpPadOe[3], 1'b0);
		clkEn = 1'b1;
		step(1);
		chk({gpPadOe[3], gpPadOut[3]}, 2'b11);
		gpioPinEnableBit[3] = 1'b0;
		$display("test freeze done");
	endtask : test_freeze

	initial begin
		test_straps();
		boot(3'h0);
		test_gpio();
		test_pad_in();
		test_freeze();
		boot(3'h6);
		test_gpio();
		end_of_test();
	end
endmodule : spfs_pin_mux_tb
